//--- pkg/fuse_store_pkg.sv
// constants and types shared by the fuse, trim and calibration store
package fuse_store_pkg;

    // ==========================================================
    // fuse array layout
    localparam int FUSE_W      = 188;
    localparam int SPARE_LSB   = 183;
    localparam int SPARE_W     = 5;
    localparam int TRIM_F_LSB  = 163;
    localparam int CAL_F_LSB   = 53;
    localparam int USER_LSB    = 0;
    localparam int USER_W      = 53;

    // ==========================================================
    // working register widths and field positions
    localparam int CAL_W       = 110;
    localparam int TRIM_W      = 20;
    localparam int CONST_W     = 11;
    localparam int NUM_CONST   = 10;
    localparam int NUM_GAIN    = 4;
    localparam int TRIM_SUB_W  = 5;
    localparam int TRIMC_LSB   = 15;
    localparam int TRIMA_LSB   = 10;
    localparam int TRIMBV_LSB  = 5;
    localparam int TRIMBTC_LSB = 0;

    // ==========================================================
    // reset and default contents
    localparam logic [SPARE_W-1:0]    SPARE_DEFAULT   = 5'h0f;
    localparam logic [CONST_W-1:0]    CONST_NOMINAL   = 11'h60c;
    localparam logic [CONST_W-1:0]    CONST_FULL      = 11'h7ff;
    localparam logic [CONST_W-1:0]    CONST_ZERO      = 11'h000;
    localparam logic [CAL_W-1:0]      CAL_DEFAULT     = {CONST_NOMINAL, CONST_NOMINAL,
                                                         CONST_NOMINAL, CONST_ZERO,
                                                         CONST_NOMINAL, CONST_FULL,
                                                         CONST_FULL, CONST_NOMINAL,
                                                         CONST_NOMINAL, CONST_NOMINAL};
    localparam logic [TRIM_SUB_W-1:0] TRIMC_DEFAULT   = 5'h04;
    localparam logic [TRIM_SUB_W-1:0] TRIMA_DEFAULT   = 5'h00;
    localparam logic [TRIM_SUB_W-1:0] TRIMBV_DEFAULT  = 5'h10;
    localparam logic [TRIM_SUB_W-1:0] TRIMBTC_DEFAULT = 5'h11;
    localparam logic [TRIM_W-1:0]     TRIM_DEFAULT    = {TRIMC_DEFAULT, TRIMA_DEFAULT,
                                                         TRIMBV_DEFAULT, TRIMBTC_DEFAULT};
    localparam logic [USER_W-1:0]     USER_DEFAULT    = 53'h0;

    // ==========================================================
    // channel configuration fields
    localparam int CFG_W        = 17;
    localparam int CFG_PATH_BIT = 9;
    localparam int CFG_GAIN_LSB = 7;
    localparam int CFG_VSEL_LSB = 14;
    localparam logic [2:0] VSEL_LAST_STORED = 3'h5;

    // ==========================================================
    // correction arithmetic
    localparam int RES_W      = 16;
    localparam int CORR_SHIFT = 10;

    // ==========================================================
    // serial target and power-up load states
    typedef enum logic [1:0] {
        SEL_CAL  = 2'b00,
        SEL_TRIM = 2'b01,
        SEL_NONE = 2'b10,
        SEL_FUSE = 2'b11
    } reg_sel_type;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_COPY = 2'b01,
        LD_DONE = 2'b11
    } load_state_type;

endpackage

//--- pkg/cal_sel_if.sv
// carrier between the store and the calibration constant chooser
`timescale 1ns/1ps
`default_nettype none
interface cal_sel_if;
    import fuse_store_pkg::*;
    logic [CAL_W-1:0]   cal_bank;
    logic               path_sel;
    logic [1:0]         gain;
    logic [2:0]         vsel;
    logic [CONST_W-1:0] sel_const;

    modport chooser (input cal_bank, input path_sel, input gain, input vsel,
                     output sel_const);
    modport user    (output cal_bank, output path_sel, output gain, output vsel,
                     input sel_const);
endinterface // cal_sel_if
`default_nettype wire

//--- design/cal_const_select.sv
// picks one calibration constant out of the packed bank, or CONST_NOMINAL for voltage selectors 6 and 7
`timescale 1ns/1ps
`default_nettype none
module cal_const_select
(
    cal_sel_if.chooser sel
);
    import fuse_store_pkg::*;

    // ==========================================================
    // selection
    always_comb
    begin
        int idx;
        idx = 0;
        if (sel.path_sel)
        begin
            idx = int'(sel.gain);
            sel.sel_const = sel.cal_bank[CAL_W-1-idx*CONST_W -: CONST_W];
        end
        else if (sel.vsel > VSEL_LAST_STORED)
        begin
            sel.sel_const = CONST_NOMINAL;
        end
        else
        begin
            idx = NUM_GAIN + int'(sel.vsel);
            sel.sel_const = sel.cal_bank[CAL_W-1-idx*CONST_W -: CONST_W];
        end
    end
endmodule // cal_const_select
`default_nettype wire

//--- design/fuse_trim_calibration_store.sv
// fuse array, power-up loader, trim and calibration registers, correction
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module fuse_trim_calibration_store
#(
    parameter logic [fuse_store_pkg::USER_W-1:0] USER_CONTENT = fuse_store_pkg::USER_DEFAULT,
    parameter logic [4:0]                        TRIMA_FACTORY = fuse_store_pkg::TRIMA_DEFAULT
)
(
    input  wire logic                                clock_i,
    input  wire logic                                rst_i,
    input  wire fuse_store_pkg::reg_sel_type         ser_sel_i,
    input  wire logic                                ser_capture_i,
    input  wire logic                                ser_shift_i,
    input  wire logic                                serial_data_in_i,
    input  wire logic                                ser_update_i,
    input  wire logic [fuse_store_pkg::CFG_W-1:0]    chan_a_config_i,
    input  wire logic [fuse_store_pkg::CFG_W-1:0]    chan_b_config_i,
    input  wire logic                                meas_chan_b_i,
    input  wire logic                                raw_valid_i,
    input  wire logic [fuse_store_pkg::RES_W-1:0]    raw_result_i,
    output logic                                     serial_data_out_o,
    output logic                                     loaded_o,
    output logic [fuse_store_pkg::CONST_W-1:0]       cal_const_o,
    output logic [fuse_store_pkg::CAL_W-1:0]         calibration_constants_o,
    output logic [fuse_store_pkg::TRIM_W-1:0]        trim_values_o,
    output logic                                     cur_switch_o,
    output logic                                     corr_valid_o,
    output logic [fuse_store_pkg::RES_W-1:0]         corr_result_o
);
    import fuse_store_pkg::*;

    // ==========================================================
    // fuse content: a constant, nothing in this block can write it
    localparam logic [TRIM_W-1:0] TRIM_FUSED = {TRIMC_DEFAULT, TRIMA_FACTORY,
                                                TRIMBV_DEFAULT, TRIMBTC_DEFAULT};
    localparam logic [FUSE_W-1:0] FUSE_CONTENT = {SPARE_DEFAULT, TRIM_FUSED,
                                                  CAL_DEFAULT, USER_CONTENT};

    // ==========================================================
    // state
    typedef struct packed {
        load_state_type      ld;
        logic [CAL_W-1:0]    cal;
        logic [TRIM_W-1:0]   trim;
        logic [FUSE_W-1:0]   shift;
        reg_sel_type         shsel;
        logic [CONST_W-1:0]  cconst;
        logic                sw;
        logic                cvalid;
        logic [RES_W-1:0]    corr;
        logic                sdo;
    } store_type;

    store_type state_r;
    store_type state_nxt;

    localparam store_type STORE_RESET = '{ld: LD_IDLE, cal: CAL_DEFAULT, trim: TRIM_DEFAULT,
                                          shift: '0, shsel: SEL_NONE, cconst: CONST_ZERO,
                                          sw: 1'b0, cvalid: 1'b0, corr: '0, sdo: 1'b0};

    // ==========================================================
    // selection inputs from the active channel
    cal_sel_if sel_bus ();

    logic [CFG_W-1:0]       act_cfg;
    logic                   path_eff;
    logic [2*RES_W-1:0]     product;
    logic [RES_W:0]         scaled;
    logic [26:0]            corr_ref;

    assign act_cfg  = meas_chan_b_i ? chan_b_config_i : chan_a_config_i;
    // channel B is forced onto the voltage path even if its bit is set
    assign path_eff = act_cfg[CFG_PATH_BIT] & ~meas_chan_b_i;

    assign sel_bus.cal_bank = state_r.cal;
    assign sel_bus.path_sel = path_eff;
    assign sel_bus.gain     = act_cfg[CFG_GAIN_LSB +: 2];
    assign sel_bus.vsel     = act_cfg[CFG_VSEL_LSB +: 3];

    cal_const_select chooser
    (
        .sel (sel_bus.chooser)
    );

    assign product = {{(RES_W-CONST_W){1'b0}}, sel_bus.sel_const} * raw_result_i;
    assign scaled  = product[CORR_SHIFT +: RES_W+1];
    // reference for the checks only, built apart from the saturating path
    assign corr_ref = ({{CONST_W{1'b0}}, raw_result_i} * {{RES_W{1'b0}}, sel_bus.sel_const})
                      >> CORR_SHIFT;

    // ==========================================================
    // next state
    always_comb
    begin
        state_nxt        = state_r;
        state_nxt.cvalid = 1'b0;

        case (state_r.ld)
            LD_IDLE:
            begin
                state_nxt.ld = LD_COPY;
            end
            LD_COPY:
            begin
                // fuse fields are copied, never written back
                state_nxt.cal  = FUSE_CONTENT[CAL_F_LSB +: CAL_W];
                state_nxt.trim = FUSE_CONTENT[TRIM_F_LSB +: TRIM_W];
                state_nxt.ld   = LD_DONE;
            end
            LD_DONE:
            begin
                state_nxt.ld = LD_DONE;
            end
            default:
            begin
                state_nxt.ld = LD_IDLE;
            end
        endcase

        // serial access; updates are ignored until the power-up load has finished
        if (ser_capture_i)
        begin
            state_nxt.shsel = ser_sel_i;
            case (ser_sel_i)
                SEL_CAL:  state_nxt.shift = {{(FUSE_W-CAL_W){1'b0}}, state_r.cal};
                SEL_TRIM: state_nxt.shift = {{(FUSE_W-TRIM_W){1'b0}}, state_r.trim};
                SEL_FUSE: state_nxt.shift = FUSE_CONTENT;
                default:  state_nxt.shift = '0;
            endcase
        end
        else if (ser_shift_i)
        begin
            // msb leaves first, new bit enters at the bottom
            state_nxt.shift = {state_r.shift[FUSE_W-2:0], serial_data_in_i};
        end

        if (ser_update_i && !ser_capture_i && state_r.ld == LD_DONE)
        begin
            case (state_r.shsel)
                SEL_CAL:  state_nxt.cal  = state_r.shift[CAL_W-1:0];
                SEL_TRIM: state_nxt.trim = state_r.shift[TRIM_W-1:0];
                default:  state_nxt.cal  = state_r.cal;
            endcase
        end

        case (state_nxt.shsel)
            SEL_CAL:  state_nxt.sdo = state_nxt.shift[CAL_W-1];
            SEL_TRIM: state_nxt.sdo = state_nxt.shift[TRIM_W-1];
            SEL_FUSE: state_nxt.sdo = state_nxt.shift[FUSE_W-1];
            default:  state_nxt.sdo = 1'b0;
        endcase

        state_nxt.cconst = sel_bus.sel_const;
        state_nxt.sw     = path_eff;

        if (raw_valid_i)
        begin
            // saturate rather than wrap: a large constant must not fold a result
            state_nxt.cvalid = 1'b1;
            state_nxt.corr   = scaled[RES_W] ? {RES_W{1'b1}} : scaled[RES_W-1:0];
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= STORE_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign serial_data_out_o       = state_r.sdo;
    assign loaded_o                = (state_r.ld == LD_DONE);
    assign cal_const_o             = state_r.cconst;
    assign calibration_constants_o = state_r.cal;
    assign trim_values_o           = state_r.trim;
    assign cur_switch_o            = state_r.sw;
    assign corr_valid_o            = state_r.cvalid;
    assign corr_result_o           = state_r.corr;

    // ==========================================================
    // checks
    a_cal_default: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r.ld == LD_IDLE) |-> (state_r.cal == CAL_DEFAULT && state_r.cal[76:66] == 11'h000))
        else $error("calibration register not at defaults before load");

    a_load_cal: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r.ld == LD_COPY) |=> (state_r.cal == FUSE_CONTENT[162:53] && loaded_o))
        else $error("fuse calibration field not copied at power-up");

    a_load_trim: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r.ld == LD_COPY) |=> (state_r.trim == FUSE_CONTENT[182:163]))
        else $error("fuse trim field not loaded at power-up");

    a_trim_default: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r.ld == LD_IDLE) |-> (state_r.trim[19:15] == 5'h04 && state_r.trim[9:5] == 5'h10
                                     && state_r.trim[4:0] == 5'h11))
        else $error("trim defaults wrong");

    a_spare_field: assert property (@(posedge clock_i) disable iff (rst_i)
        ser_capture_i && ser_sel_i == SEL_FUSE |=> state_r.shift[187:183] == 5'h0f)
        else $error("spare fuse bits not hex F");

    a_cal_write: assert property (@(posedge clock_i) disable iff (rst_i)
        (ser_update_i && !ser_capture_i && loaded_o && state_r.shsel == SEL_CAL)
        |=> (state_r.cal == $past(state_r.shift[109:0])))
        else $error("serial write to calibration register lost");

    a_trim_write: assert property (@(posedge clock_i) disable iff (rst_i)
        (ser_update_i && !ser_capture_i && loaded_o && state_r.shsel == SEL_TRIM)
        |=> (state_r.trim == $past(state_r.shift[19:0])))
        else $error("serial write to trim register lost");

    a_fuse_intact: assert property (@(posedge clock_i) disable iff (rst_i)
        (ser_update_i && !ser_capture_i && loaded_o && state_r.shsel == SEL_FUSE)
        |=> (state_r.cal == $past(state_r.cal) && state_r.trim == $past(state_r.trim)))
        else $error("update against the fuse target changed a register");

    a_gain_pick: assert property (@(posedge clock_i) disable iff (rst_i)
        (path_eff && act_cfg[8:7] == 2'b00) |=> (cal_const_o == $past(state_r.cal[109:99])))
        else $error("gain code 0 did not pick current gain constant 1");

    a_volt_pick: assert property (@(posedge clock_i) disable iff (rst_i)
        (!path_eff && act_cfg[16:14] == 3'h5) |=> (cal_const_o == $past(state_r.cal[10:0])))
        else $error("selector 5 did not pick voltage constant 5");

    a_fixed_const: assert property (@(posedge clock_i) disable iff (rst_i)
        (!path_eff && act_cfg[16:15] == 2'b11) |=> (cal_const_o == 11'h60c))
        else $error("selector 6 or 7 did not give 1548");

    a_chan_b_volt: assert property (@(posedge clock_i) disable iff (rst_i)
        meas_chan_b_i |=> !cur_switch_o)
        else $error("channel B closed the current switch");

    a_corr_result: assert property (@(posedge clock_i) disable iff (rst_i)
        raw_valid_i |=> corr_valid_o && (corr_result_o == (($past(corr_ref) > 27'h000ffff) ?
                        16'hffff : $past(corr_ref[15:0]))))
        else $error("measurement not corrected with selected constant");

    a_gain_last: assert property (@(posedge clock_i) disable iff (rst_i)
        (path_eff && act_cfg[8:7] == 2'b11) |=> (cal_const_o == $past(state_r.cal[76:66])))
        else $error("gain code 3 did not pick current gain constant 4");

    a_volt_first: assert property (@(posedge clock_i) disable iff (rst_i)
        (!path_eff && act_cfg[16:14] == 3'h0) |=> (cal_const_o == $past(state_r.cal[65:55])))
        else $error("selector 0 did not pick voltage constant 0");

    a_chan_a_path: assert property (@(posedge clock_i) disable iff (rst_i)
        (!meas_chan_b_i && chan_a_config_i[9]) |=> cur_switch_o)
        else $error("current path bit did not close the current switch");

    a_trim_first: assert property (@(posedge clock_i) disable iff (rst_i)
        (ser_capture_i && ser_sel_i == SEL_TRIM)
        |=> (serial_data_out_o == $past(state_r.trim[19])))
        else $error("trim read did not start with its top bit");

    a_fuse_shift: assert property (@(posedge clock_i) disable iff (rst_i)
        (ser_shift_i && !ser_capture_i && state_r.shsel == SEL_FUSE)
        |=> (serial_data_out_o == $past(state_r.shift[186])))
        else $error("fuse read bit order broken");

    a_regs_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        (loaded_o && !ser_update_i)
        |=> (state_r.cal == $past(state_r.cal) && state_r.trim == $past(state_r.trim)))
        else $error("register changed without a serial update");

    a_load_stays: assert property (@(posedge clock_i) disable iff (rst_i)
        loaded_o |=> loaded_o)
        else $error("power-up load flag dropped");

    a_valid_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        !raw_valid_i |=> !corr_valid_o)
        else $error("result flagged without a measurement");

endmodule // fuse_trim_calibration_store
`default_nettype wire

//--- sim/host_serial_model.sv
// host microcontroller model at the serial register port
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
(
    input  wire logic                   clock_i,
    input  wire logic                   serial_data_out_i,
    output var fuse_store_pkg::reg_sel_type ser_sel_o,
    output logic                        ser_capture_o,
    output logic                        ser_shift_o,
    output logic                        serial_data_in_o,
    output logic                        ser_update_o
);
    import fuse_store_pkg::*;
    // ==========================================================
    // weak fuse cells: 80 clocks a bit keeps reads at 500 kHz
    localparam int FUSE_BIT_CLKS = 80;

    initial
    begin
        ser_sel_o        = SEL_NONE;
        ser_capture_o    = 1'b0;
        ser_shift_o      = 1'b0;
        serial_data_in_o = 1'b0;
        ser_update_o     = 1'b0;
    end

    // ==========================================================
    // one frame: capture, n shifts msb first both ways, then update
    task automatic xfer(input reg_sel_type sel, input int n, input logic [187:0] wd,
                        input logic upd, output logic [187:0] rd);
        int gap;
        rd  = '0;
        gap = (sel == SEL_FUSE) ? FUSE_BIT_CLKS - 1 : 0;
        @(posedge clock_i);
        #1;
        ser_sel_o     = sel;
        ser_capture_o = 1'b1;
        @(posedge clock_i);
        #1;
        ser_capture_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            rd[i]            = serial_data_out_i;
            serial_data_in_o = wd[i];
            ser_shift_o      = 1'b1;
            @(posedge clock_i);
            #1;
            if (gap > 0)
            begin
                // line released between bits: show the inverse, not a held value
                ser_shift_o      = 1'b0;
                serial_data_in_o = ~wd[i];
                repeat (gap) @(posedge clock_i);
                #1;
            end
        end
        ser_shift_o      = 1'b0;
        ser_update_o     = upd;
        serial_data_in_o = ~serial_data_in_o;
        @(posedge clock_i);
        #1;
        ser_update_o = 1'b0;
    endtask
endmodule // host_serial_model
`default_nettype wire

//--- sim/fuse_trim_calibration_store_tb.sv
// self-checking bench for the fuse, trim and calibration store
`timescale 1ns/1ps
`default_nettype none
module fuse_trim_calibration_store_tb;
    import fuse_store_pkg::*;
    // ==========================================================
    // expected contents; 11'h60c is 1548, 11'h7ff is 2047
    localparam logic [52:0]  USER_PAT = 53'h1_5a5a_c3c3_0f0f;
    localparam logic [109:0] CAL_EXP  = {11'h60c, 11'h60c, 11'h60c, 11'h000, 11'h60c,
                                         11'h7ff, 11'h7ff, 11'h60c, 11'h60c, 11'h60c};
    localparam logic [19:0]  TRIM_EXP = {5'h04, 5'h00, 5'h10, 5'h11};
    localparam logic [187:0] FUSE_EXP = {5'h0f, TRIM_EXP, CAL_EXP, USER_PAT};

    logic clock_i, rst_i, ser_capture_i, ser_shift_i, serial_data_in_i, ser_update_i;
    logic meas_chan_b_i, raw_valid_i, serial_data_out_o, loaded_o, cur_switch_o;
    logic corr_valid_o;
    reg_sel_type    ser_sel_i;
    logic [16:0]    chan_a_config_i, chan_b_config_i;
    logic [15:0]    raw_result_i, corr_result_o;
    logic [10:0]    cal_const_o;
    logic [109:0]   calibration_constants_o, cal_pat;
    logic [19:0]    trim_values_o;
    logic [187:0]   rd;
    int             err_count, tests_run;

    fuse_trim_calibration_store #(.USER_CONTENT(USER_PAT)) uut
    (
        .clock_i(clock_i), .rst_i(rst_i), .ser_sel_i(ser_sel_i),
        .ser_capture_i(ser_capture_i), .ser_shift_i(ser_shift_i),
        .serial_data_in_i(serial_data_in_i), .ser_update_i(ser_update_i),
        .chan_a_config_i(chan_a_config_i), .chan_b_config_i(chan_b_config_i),
        .meas_chan_b_i(meas_chan_b_i), .raw_valid_i(raw_valid_i),
        .raw_result_i(raw_result_i), .serial_data_out_o(serial_data_out_o),
        .loaded_o(loaded_o), .cal_const_o(cal_const_o),
        .calibration_constants_o(calibration_constants_o),
        .trim_values_o(trim_values_o), .cur_switch_o(cur_switch_o),
        .corr_valid_o(corr_valid_o), .corr_result_o(corr_result_o)
    );

    host_serial_model host
    (
        .clock_i(clock_i), .serial_data_out_i(serial_data_out_o), .ser_sel_o(ser_sel_i),
        .ser_capture_o(ser_capture_i), .ser_shift_o(ser_shift_i),
        .serial_data_in_o(serial_data_in_i), .ser_update_o(ser_update_i)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // ==========================================================
    // helpers
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string name, input logic [187:0] seen, input logic [187:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [10:0] kval(input int k);
        return 11'h100 + 11'(k * 37);
    endfunction

    function automatic logic [16:0] cfg(input logic [2:0] vs, input logic p,
                                        input logic [1:0] g);
        return {vs, 4'h0, p, g, 7'h00};
    endfunction

    // fuse cal and trim fields are the defaults, so one check serves both moments
    task automatic do_reset();
        int n;
        rst_i = 1'b1;
        repeat (6) @(posedge clock_i);
        #1;
        chk("cal in reset", calibration_constants_o, CAL_EXP);
        chk("trim in reset", trim_values_o, TRIM_EXP);
        rst_i = 1'b0;
        n     = 0;
        while (loaded_o !== 1'b1 && n < 20)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("loaded", loaded_o, 1'b1);
        chk("cal loaded", calibration_constants_o, CAL_EXP);
        chk("trim loaded", trim_values_o, TRIM_EXP);
    endtask

    // one measurement; a raw 1024 returns the chosen constant itself
    task automatic meas(input logic [16:0] ca, input logic [16:0] cb, input logic b,
                        input logic [15:0] r, input logic [10:0] ec, input logic esw);
        logic [26:0] p;
        p               = ({11'h000, r} * {16'h0000, ec}) >> 10;
        chan_a_config_i = ca;
        chan_b_config_i = cb;
        meas_chan_b_i   = b;
        raw_result_i    = r;
        raw_valid_i     = 1'b1;
        @(posedge clock_i);
        #1;
        raw_valid_i = 1'b0;
        chk("const", cal_const_o, ec);
        chk("switch", cur_switch_o, esw);
        chk("valid", corr_valid_o, 1'b1);
        chk("result", corr_result_o, (p > 27'h000ffff) ? 16'hffff : p[15:0]);
        @(posedge clock_i);
        #1;
        chk("valid end", corr_valid_o, 1'b0);
    endtask

    // ==========================================================
    // tests
    initial
    begin
        err_count = 0;
        tests_run = 0;
        rst_i = 1'b1;
        chan_a_config_i = '0;
        chan_b_config_i = '0;
        meas_chan_b_i = 1'b0;
        raw_valid_i = 1'b0;
        raw_result_i = '0;
        do_reset();
        $display("test reset done");
        // update aimed at the fuses must be ignored
        host.xfer(SEL_FUSE, 188, ~FUSE_EXP, 1'b1, rd);
        chk("fuse read", rd, FUSE_EXP);
        host.xfer(SEL_FUSE, 188, '0, 1'b0, rd);
        chk("fuse reread", rd, FUSE_EXP);
        chk("cal kept", calibration_constants_o, CAL_EXP);
        $display("test fuse done");
        host.xfer(SEL_TRIM, 20, 188'habcde, 1'b1, rd);
        chk("trim read", rd[19:0], TRIM_EXP);
        chk("trim write", trim_values_o, 20'habcde);
        host.xfer(SEL_NONE, 20, 188'h12345, 1'b1, rd);
        chk("trim kept", trim_values_o, 20'habcde);
        for (int k = 0; k < 10; k++)
            cal_pat[109 - 11 * k -: 11] = kval(k);
        host.xfer(SEL_CAL, 110, {78'h0, cal_pat}, 1'b1, rd);
        chk("cal read", rd[109:0], CAL_EXP);
        chk("cal write", calibration_constants_o, cal_pat);
        host.xfer(SEL_TRIM, 20, '0, 1'b0, rd);
        chk("trim readback", rd[19:0], 20'habcde);
        $display("test serial done");
        for (int g = 0; g < 4; g++)
            meas(cfg(3'h6, 1'b1, 2'(g)), '0, 1'b0, 16'h0400, kval(g), 1'b1);
        for (int s = 0; s < 8; s++)
            meas(cfg(3'(s), 1'b0, 2'h3), cfg(3'h7, 1'b0, 2'h0), 1'b0, 16'h0400,
                 (s < 6) ? kval(4 + s) : 11'h60c, 1'b0);
        meas(cfg(3'h7, 1'b1, 2'h0), cfg(3'h2, 1'b1, 2'h1), 1'b1, 16'h0400,
             kval(6), 1'b0);
        meas(cfg(3'h6, 1'b0, 2'h0), '0, 1'b0, 16'h0800, 11'h60c, 1'b0);
        meas(cfg(3'h6, 1'b0, 2'h0), '0, 1'b0, 16'hffff, 11'h60c, 1'b0);
        $display("test select done");
        @(posedge clock_i);
        #1;
        do_reset();
        $display("test second reset done");
        end_sim();
    end

    initial
    begin
        repeat (80000) @(posedge clock_i);
        err_count++;
        end_sim();
    end
endmodule // fuse_trim_calibration_store_tb
`default_nettype wire
